// ===== verilog/sml_map.vh
`ifndef SML_MAP_VH
`define SML_MAP_VH

// APB register byte offsets
`define SML_OFS_CTRL      8'h00
`define SML_OFS_ST0       8'h04
`define SML_OFS_ST1       8'h08
`define SML_OFS_PROD      8'h0c
`define SML_OFS_ACC       8'h10
`define SML_OFS_MCAND     8'h14
`define SML_OFS_SHIFT_T   8'h18
`define SML_OFS_BITIDX_T  8'h1c
`define SML_OFS_STATUS    8'h20

// Control register fields
`define SML_CTRL_TRM_BIT  0
`define SML_CTRL_PM_LSB   1
`define SML_CTRL_PM_MSB   2

// Status word fields
`define SML_PTR_LSB       13
`define SML_PTR_MSB       15
`define SML_GLOBAL_IRQ_MASK_BIT      9

// Temporary register widths
`define SML_SHIFT_T_W     5
`define SML_BITIDX_T_W    4

// Instruction codes on the issue port
`define SML_OP_STATUS     2'h0
`define SML_OP_PROD_HIGH  2'h1
`define SML_OP_MCAND      2'h2
`define SML_OP_MCAND_ACC  2'h3

// Product shift modes
`define SML_PM_NONE       2'h0
`define SML_PM_LEFT1      2'h1
`define SML_PM_LEFT4      2'h2
`define SML_PM_RIGHT6     2'h3

// Cycle figures
`define SML_CYC_STATUS    2'h2
`define SML_CYC_LOAD      2'h1
`define SML_CYC_W         11

// Reset values
`define SML_RST_CTRL      3'h0
`define SML_RST_WORD16    16'h0000
`define SML_RST_WORD32    32'h0000_0000

`endif

// ===== verilog/sml_cycle_timer.v
`timescale 1ns/1ps
`include "sml_map.vh"

module sml_cycle_timer (
    input  wire       clk_in,
    input  wire       rst_n_in,
    input  wire       ce_in,
    input  wire       start_in,
    input  wire [1:0] base_in,
    input  wire       periph_in,
    input  wire       single_access_ram_in,
    input  wire [7:0] rpt_in,
    output wire       busy_out,
    output reg        done_out,
    output reg  [`SML_CYC_W-1:0] last_cycles_out
);
    reg  [`SML_CYC_W-1:0] count_reg;
    reg  [`SML_CYC_W-1:0] total;
    wire [`SML_CYC_W-1:0] iters = {3'h0, rpt_in} + {{(`SML_CYC_W-1){1'b0}}, 1'b1};
    wire [`SML_CYC_W-1:0] per   = {{(`SML_CYC_W-2){1'b0}}, base_in} + {{(`SML_CYC_W-1){1'b0}}, periph_in};
    wire [2*`SML_CYC_W-1:0] prod = iters * per;

    always @* begin
        total = prod[`SML_CYC_W-1:0] + {{(`SML_CYC_W-1){1'b0}}, single_access_ram_in};
    end

    assign busy_out = (count_reg != {`SML_CYC_W{1'b0}});

    // Instruction occupies its full cycle count before the next is accepted
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            count_reg       <= {`SML_CYC_W{1'b0}};
            done_out        <= 1'b0;
            last_cycles_out <= {`SML_CYC_W{1'b0}};
        end else if (ce_in) begin
            done_out <= 1'b0;
            if (start_in) begin
                count_reg       <= total - {{(`SML_CYC_W-1){1'b0}}, 1'b1};
                last_cycles_out <= total;
                if (total == {{(`SML_CYC_W-1){1'b0}}, 1'b1}) begin
                    done_out <= 1'b1;
                end
            end else if (busy_out) begin
                count_reg <= count_reg - {{(`SML_CYC_W-1){1'b0}}, 1'b1};
                if (count_reg == {{(`SML_CYC_W-1){1'b0}}, 1'b1}) begin
                    done_out <= 1'b1;
                end
            end
        end
    end
endmodule

// ===== verilog/sml_load_unit.v
`timescale 1ns/1ps
`include "sml_map.vh"

// Contract
// [RQ1] A status load copies the data word into status word zero or one as the selector says.
// [RQ2] Loading status word zero keeps the previous global interrupt mask bit.
// [RQ3] Loading status word zero updates the pointer but leaves the pointer buffer in status word one alone.
// [RQ4] Every status load sets the pointer from bits 13 to 15 of the word and ignores any next-pointer value.
// [RQ5] Loading status word one writes the pointer buffer value into the pointer as well.
// [RQ6] A multiplicand load writes the data word into the primary multiplicand register.
// [RQ7] With legacy mode bit 0 a multiplicand load also writes both temporary registers.
// [RQ8] The temporary registers hold only 5 and 4 bits and wider values are truncated.
// [RQ9] The multiplicand registers are mapped so that memory accesses can read and write them.
// [RQ10] A load into a peripheral mapped register takes one extra cycle, per iteration under repeat.
// [RQ11] Operand and code in the same single-access RAM block add one cycle.
// [RQ12] The accumulate variant also adds the shifted product to the accumulator.
// [RQ13] A product high load writes bits 31 to 16 of the product and keeps bits 15 to 0.
module sml_load_unit (
    input  wire        CLK_IN,
    input  wire        RST_N_IN,
    input  wire        CE_IN,
    input  wire        PSEL_IN,
    input  wire        PENABLE_IN,
    input  wire        PWRITE_IN,
    input  wire [7:0]  PADDR_IN,
    input  wire [31:0] PWDATA_IN,
    output reg  [31:0] PRDATA_OUT,
    output wire        PREADY_OUT,
    output wire        PSLVERR_OUT,
    input  wire        INSTR_VALID_IN,
    input  wire [1:0]  INSTR_OP_IN,
    input  wire        INSTR_SEL_IN,
    input  wire [15:0] INSTR_DATA_IN,
    input  wire        INSTR_NEXT_PTR_VALID_IN,
    input  wire [2:0]  INSTR_NEXT_PTR_IN,
    input  wire        INSTR_PERIPH_IN,
    input  wire        INSTR_SAME_SINGLE_ACCESS_RAM_IN,
    input  wire [7:0]  INSTR_RPT_IN,
    output wire        INSTR_READY_OUT,
    output wire        INSTR_DONE_OUT,
    output wire [15:0] STATUS_ZERO_OUT,
    output wire [15:0] STATUS_ONE_OUT,
    output wire [2:0]  AUX_PTR_OUT,
    output wire [31:0] PRODUCT_OUT,
    output wire [31:0] ACCUM_OUT,
    output wire [15:0] MCAND_OUT
);
    reg  [2:0]  ctrl_reg;
    reg  [15:0] st0_reg;
    reg  [15:0] st1_reg;
    reg  [31:0] prod_reg;
    reg  [31:0] acc_reg;
    reg  [15:0] mcand_reg;
    reg  [`SML_SHIFT_T_W-1:0]  shift_t_reg;
    reg  [`SML_BITIDX_T_W-1:0] bitidx_t_reg;

    reg  [15:0] st0_next;
    reg  [15:0] st1_next;
    reg  [31:0] prod_next;
    reg  [31:0] acc_next;
    reg  [15:0] mcand_next;
    reg  [`SML_SHIFT_T_W-1:0]  shift_t_next;
    reg  [`SML_BITIDX_T_W-1:0] bitidx_t_next;
    reg  [2:0]  ctrl_next;
    reg  [1:0]  base_cyc;

    wire        timer_busy;
    wire [`SML_CYC_W-1:0] last_cycles;
    wire        legacy_temp_mode   = ctrl_reg[`SML_CTRL_TRM_BIT];
    wire [1:0]  product_shift_mode = ctrl_reg[`SML_CTRL_PM_MSB:`SML_CTRL_PM_LSB];

    wire        issue   = INSTR_VALID_IN & ~timer_busy;
    wire        apb_acc = PSEL_IN & PENABLE_IN;
    wire        apb_wr  = apb_acc & PWRITE_IN;
    wire        mapped  = addr_hit(PADDR_IN);

    assign PREADY_OUT      = 1'b1;
    assign PSLVERR_OUT     = apb_acc & ~mapped;
    assign INSTR_READY_OUT = ~timer_busy;
    assign STATUS_ZERO_OUT = st0_reg;
    assign STATUS_ONE_OUT  = st1_reg;
    assign AUX_PTR_OUT     = st0_reg[`SML_PTR_MSB:`SML_PTR_LSB];
    assign PRODUCT_OUT     = prod_reg;
    assign ACCUM_OUT       = acc_reg;
    assign MCAND_OUT       = mcand_reg;

    function addr_hit;
        input [7:0] a;
        begin
            addr_hit = (a == `SML_OFS_CTRL) || (a == `SML_OFS_ST0) || (a == `SML_OFS_ST1) ||
                       (a == `SML_OFS_PROD) || (a == `SML_OFS_ACC) || (a == `SML_OFS_MCAND) ||
                       (a == `SML_OFS_SHIFT_T) || (a == `SML_OFS_BITIDX_T) || (a == `SML_OFS_STATUS);
        end
    endfunction

    // Right shift is arithmetic so negative products stay negative
    function [31:0] shift_product;
        input [31:0] p;
        input [1:0]  mode;
        begin
            case (mode)
                `SML_PM_NONE:   shift_product = p;
                `SML_PM_LEFT1:  shift_product = {p[30:0], 1'b0};
                `SML_PM_LEFT4:  shift_product = {p[27:0], 4'h0};
                `SML_PM_RIGHT6: shift_product = {{6{p[31]}}, p[31:6]};
                default:        shift_product = p;
            endcase
        end
    endfunction

    always @* begin
        ctrl_next     = ctrl_reg;
        st0_next      = st0_reg;
        st1_next      = st1_reg;
        prod_next     = prod_reg;
        acc_next      = acc_reg;
        mcand_next    = mcand_reg;
        shift_t_next  = shift_t_reg;
        bitidx_t_next = bitidx_t_reg;
        base_cyc      = `SML_CYC_LOAD;

        // Memory-style access to the same registers from the bus
        // [RQ9] mapped register writes
        if (apb_wr) begin
            case (PADDR_IN)
                `SML_OFS_CTRL:     ctrl_next     = PWDATA_IN[2:0];
                `SML_OFS_ST0:      st0_next      = PWDATA_IN[15:0];
                `SML_OFS_ST1:      st1_next      = PWDATA_IN[15:0];
                `SML_OFS_PROD:     prod_next     = PWDATA_IN;
                `SML_OFS_ACC:      acc_next      = PWDATA_IN;
                `SML_OFS_MCAND:    mcand_next    = PWDATA_IN[15:0];
                `SML_OFS_SHIFT_T:  shift_t_next  = PWDATA_IN[`SML_SHIFT_T_W-1:0];
                `SML_OFS_BITIDX_T: bitidx_t_next = PWDATA_IN[`SML_BITIDX_T_W-1:0];
                default:           ctrl_next     = ctrl_reg;
            endcase
        end

        // An instruction issued in the same cycle as a bus write overrides it
        case (INSTR_OP_IN)
            `SML_OP_STATUS: begin
                base_cyc = `SML_CYC_STATUS;
                if (issue) begin
                    if (!INSTR_SEL_IN) begin
                        // [RQ1] select word zero
                        st0_next = INSTR_DATA_IN;
                        // [RQ2] keep interrupt mask
                        st0_next[`SML_GLOBAL_IRQ_MASK_BIT] = st0_reg[`SML_GLOBAL_IRQ_MASK_BIT];
                        // [RQ3] buffer left alone
                        st1_next = st1_reg;
                    end else begin
                        // [RQ1] select word one
                        st1_next = INSTR_DATA_IN;
                        // [RQ5] buffer copied to pointer
                        st0_next[`SML_PTR_MSB:`SML_PTR_LSB] = INSTR_DATA_IN[`SML_PTR_MSB:`SML_PTR_LSB];
                    end
                    // [RQ4] pointer from word, next pointer ignored
                    st0_next[`SML_PTR_MSB:`SML_PTR_LSB] = INSTR_DATA_IN[`SML_PTR_MSB:`SML_PTR_LSB];
                end
            end
            `SML_OP_PROD_HIGH: begin
                if (issue) begin
                    // [RQ13] upper half only
                    prod_next = {INSTR_DATA_IN, prod_reg[15:0]};
                end
            end
            default: begin
                if (issue) begin
                    // [RQ6] primary multiplicand
                    mcand_next = INSTR_DATA_IN;
                    if (!legacy_temp_mode) begin
                        // [RQ7] [RQ8] truncated copies into temporaries
                        shift_t_next  = INSTR_DATA_IN[`SML_SHIFT_T_W-1:0];
                        bitidx_t_next = INSTR_DATA_IN[`SML_BITIDX_T_W-1:0];
                    end
                    if (INSTR_OP_IN == `SML_OP_MCAND_ACC) begin
                        // [RQ12] accumulate shifted product
                        acc_next = acc_reg + shift_product(prod_reg, product_shift_mode);
                    end
                end
            end
        endcase

        // Pointer in the indirect field is never used by these loads
        if (INSTR_NEXT_PTR_VALID_IN && INSTR_NEXT_PTR_IN != 3'h0) begin
            base_cyc = base_cyc;
        end
    end

    always @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            ctrl_reg     <= `SML_RST_CTRL;
            st0_reg      <= `SML_RST_WORD16;
            st1_reg      <= `SML_RST_WORD16;
            prod_reg     <= `SML_RST_WORD32;
            acc_reg      <= `SML_RST_WORD32;
            mcand_reg    <= `SML_RST_WORD16;
            shift_t_reg  <= {`SML_SHIFT_T_W{1'b0}};
            bitidx_t_reg <= {`SML_BITIDX_T_W{1'b0}};
        end else if (CE_IN) begin
            ctrl_reg     <= ctrl_next;
            st0_reg      <= st0_next;
            st1_reg      <= st1_next;
            prod_reg     <= prod_next;
            acc_reg      <= acc_next;
            mcand_reg    <= mcand_next;
            shift_t_reg  <= shift_t_next;
            bitidx_t_reg <= bitidx_t_next;
        end
    end

    // [RQ9] mapped register reads
    always @* begin
        PRDATA_OUT = 32'h0000_0000;
        if (PSEL_IN && !PWRITE_IN) begin
            case (PADDR_IN)
                `SML_OFS_CTRL:     PRDATA_OUT = {29'h0, ctrl_reg};
                `SML_OFS_ST0:      PRDATA_OUT = {16'h0, st0_reg};
                `SML_OFS_ST1:      PRDATA_OUT = {16'h0, st1_reg};
                `SML_OFS_PROD:     PRDATA_OUT = prod_reg;
                `SML_OFS_ACC:      PRDATA_OUT = acc_reg;
                `SML_OFS_MCAND:    PRDATA_OUT = {16'h0, mcand_reg};
                `SML_OFS_SHIFT_T:  PRDATA_OUT = {27'h0, shift_t_reg};
                `SML_OFS_BITIDX_T: PRDATA_OUT = {28'h0, bitidx_t_reg};
                `SML_OFS_STATUS:   PRDATA_OUT = {20'h0, last_cycles, timer_busy};
                default:           PRDATA_OUT = 32'h0000_0000;
            endcase
        end
    end

    // [RQ10] [RQ11] extra cycles for peripheral target and shared block
    sml_cycle_timer u_timer (
        .clk_in          (CLK_IN),
        .rst_n_in        (RST_N_IN),
        .ce_in           (CE_IN),
        .start_in        (issue),
        .base_in         (base_cyc),
        .periph_in       (INSTR_PERIPH_IN),
        .single_access_ram_in        (INSTR_SAME_SINGLE_ACCESS_RAM_IN),
        .rpt_in          (INSTR_RPT_IN),
        .busy_out        (timer_busy),
        .done_out        (INSTR_DONE_OUT),
        .last_cycles_out (last_cycles)
    );
endmodule

// ===== tb/sml_checker.sv
`timescale 1ns/1ps
`include "sml_map.vh"
module sml_checker (
    input wire        CLK_IN,
    input wire        RST_N_IN,
    input wire        CE_IN,
    input wire        PSEL_IN,
    input wire        INSTR_VALID_IN,
    input wire [1:0]  INSTR_OP_IN,
    input wire        INSTR_SEL_IN,
    input wire [15:0] INSTR_DATA_IN,
    input wire        INSTR_PERIPH_IN,
    input wire        INSTR_SAME_SINGLE_ACCESS_RAM_IN,
    input wire [7:0]  INSTR_RPT_IN,
    input wire        INSTR_READY_OUT,
    input wire        INSTR_DONE_OUT,
    input wire [15:0] STATUS_ZERO_OUT,
    input wire [15:0] STATUS_ONE_OUT,
    input wire [2:0]  AUX_PTR_OUT,
    input wire [31:0] PRODUCT_OUT,
    input wire [31:0] ACCUM_OUT,
    input wire [15:0] MCAND_OUT
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    wire iss = INSTR_VALID_IN & INSTR_READY_OUT & CE_IN;
    wire stl = iss & (INSTR_OP_IN == `SML_OP_STATUS);
    wire ld1 = iss & (INSTR_OP_IN != `SML_OP_STATUS) & (INSTR_RPT_IN == 8'h00) & !INSTR_SAME_SINGLE_ACCESS_RAM_IN;
    sequence s_gap1;
        !INSTR_DONE_OUT ##1 INSTR_DONE_OUT;
    endsequence
    sequence s_gap2;
        !INSTR_DONE_OUT ##1 s_gap1;
    endsequence
    a_zero_copy: assert property (
        stl & !INSTR_SEL_IN |=> STATUS_ZERO_OUT ==
        {$past(INSTR_DATA_IN[15:10]), $past(STATUS_ZERO_OUT[9]), $past(INSTR_DATA_IN[8:0])})
        else $error("status zero load wrong");
    a_ptr_word: assert property (stl |=> AUX_PTR_OUT == $past(INSTR_DATA_IN[15:13]))
        else $error("pointer not from word");
    a_buffer_kept: assert property (stl & !INSTR_SEL_IN & !PSEL_IN |=> $stable(STATUS_ONE_OUT))
        else $error("status one disturbed");
    a_one_copy: assert property (
        stl & INSTR_SEL_IN |=> STATUS_ONE_OUT == $past(INSTR_DATA_IN) && AUX_PTR_OUT == STATUS_ONE_OUT[15:13])
        else $error("status one load wrong");
    a_prod_high: assert property (
        iss & INSTR_OP_IN == `SML_OP_PROD_HIGH |=> PRODUCT_OUT == {$past(INSTR_DATA_IN), $past(PRODUCT_OUT[15:0])})
        else $error("product high load wrong");
    a_mcand_load: assert property (iss & INSTR_OP_IN[1] |=> MCAND_OUT == $past(INSTR_DATA_IN))
        else $error("multiplicand load wrong");
    a_acc_kept: assert property (
        iss & INSTR_OP_IN != `SML_OP_MCAND_ACC & !PSEL_IN |=> $stable(ACCUM_OUT))
        else $error("accumulator changed without accumulate");
    a_done_fast: assert property (ld1 & !INSTR_PERIPH_IN |=> INSTR_DONE_OUT)
        else $error("single cycle load late");
    a_periph_extra: assert property (ld1 & INSTR_PERIPH_IN |=> s_gap1)
        else $error("peripheral extra cycle wrong");
    a_block_extra: assert property (
        stl & !INSTR_PERIPH_IN & INSTR_RPT_IN == 8'h00 & INSTR_SAME_SINGLE_ACCESS_RAM_IN |=> s_gap2)
        else $error("same block extra cycle wrong");
endmodule

bind sml_load_unit sml_checker chk (.CLK_IN, .RST_N_IN, .CE_IN, .PSEL_IN, .INSTR_VALID_IN, .INSTR_OP_IN,
    .INSTR_SEL_IN, .INSTR_DATA_IN, .INSTR_PERIPH_IN, .INSTR_SAME_SINGLE_ACCESS_RAM_IN, .INSTR_RPT_IN, .INSTR_READY_OUT,
    .INSTR_DONE_OUT, .STATUS_ZERO_OUT, .STATUS_ONE_OUT, .AUX_PTR_OUT, .PRODUCT_OUT, .ACCUM_OUT, .MCAND_OUT);

// ===== tb/sml_data_mem.sv
`timescale 1ns/1ps
module sml_data_mem (
    input  wire        clk_in,
    input  wire        rd_in,
    input  wire [7:0]  addr_in,
    input  wire        wr_in,
    input  wire [15:0] wdata_in,
    output reg  [15:0] word_out,
    output wire        same_block_out
);
    reg [15:0] mem [0:255];
    reg [15:0] last_reg = 16'h0000;
    // Upper half shares the code block, so those operands cost a cycle
    assign same_block_out = rd_in & addr_in[7];
    // Undriven bus shows the inverse so stale data never looks valid
    always @* word_out = rd_in ? mem[addr_in] : ~last_reg;
    always @(posedge clk_in) begin
        if (wr_in)
            mem[addr_in] <= wdata_in;
        if (rd_in)
            last_reg <= mem[addr_in];
    end
endmodule

// ===== tb/sml_load_unit_tb_top.sv
`timescale 1ns/1ps
module sml_load_unit_tb_top;
    reg         clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    reg         iv = 1'b0, sel = 1'b0, per = 1'b0, mwr = 1'b0, legacy = 1'b0, ce = 1'b1;
    reg  [1:0]  op = 2'h0, mode = 2'h0;
    reg  [3:0]  nxt = 4'h0, t2 = 4'h0;
    reg  [4:0]  t1 = 5'h00;
    reg  [7:0]  paddr = 8'h00, maddr = 8'h00, rpt = 8'h00;
    reg  [10:0] lastn = 11'h000;
    reg  [15:0] mwd = 16'h0000, sw0 = 16'h0000, sw1 = 16'h0000, mc = 16'h0000;
    reg  [31:0] pwdata = 32'h0, prod = 32'h0, acc = 32'h0, rv;
    reg  [15:0] tmem [0:255];
    wire [31:0] prdata;
    wire [15:0] mword;
    wire        pready, pslverr, ready, done, same;
    integer     error_cnt = 0, cmp_count = 0, cyc = 0, i, j;
    reg  [32:0] exp_rd [$];
    reg  [10:0] exp_cyc [$];
    always #12.5 clk = ~clk;
    sml_data_mem mem (.clk_in(clk), .rd_in(iv), .addr_in(maddr), .wr_in(mwr), .wdata_in(mwd),
        .word_out(mword), .same_block_out(same));
    sml_load_unit uut (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .INSTR_VALID_IN(iv), .INSTR_OP_IN(op), .INSTR_SEL_IN(sel),
        .INSTR_DATA_IN(mword), .INSTR_NEXT_PTR_VALID_IN(nxt[3]), .INSTR_NEXT_PTR_IN(nxt[2:0]),
        .INSTR_PERIPH_IN(per), .INSTR_SAME_SINGLE_ACCESS_RAM_IN(same), .INSTR_RPT_IN(rpt), .INSTR_READY_OUT(ready),
        .INSTR_DONE_OUT(done), .STATUS_ZERO_OUT(), .STATUS_ONE_OUT(), .AUX_PTR_OUT(), .PRODUCT_OUT(),
        .ACCUM_OUT(), .MCAND_OUT());
    task test_done;
        begin
            $display("errors %0d compares %0d", error_cnt, cmp_count);
            if (error_cnt == 0 && cmp_count > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task chk_rd(input [32:0] g, input [32:0] e);
        begin
            cmp_count++;
            if (g !== e) begin
                error_cnt++;
                $display("CHECK FAILED %0t value %h exp %h", $time, g, e);
            end
        end
    endtask
    task chk_cyc(input [10:0] g, input [10:0] e);
        chk_rd({22'h0, g}, {22'h0, e});
    endtask
    always @(posedge clk) begin
        if (psel && pen && pready === 1'b1 && !pwr)
            chk_rd({pslverr, prdata}, exp_rd.pop_front());
        if (done === 1'b1)
            chk_cyc(cyc[10:0], exp_cyc.pop_front());
        cyc = (iv && ready === 1'b1) ? 1 : cyc + 1;
    end
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge clk);
            psel   <= 1'b1;
            pwr    <= w;
            paddr  <= a;
            pwdata <= d;
            @(posedge clk);
            pen <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1)
                @(posedge clk);
            psel <= 1'b0;
            pen  <= 1'b0;
        end
    endtask
    task rd(input logic [7:0] a, input logic [32:0] e);
        begin
            exp_rd.push_back(e);
            apb(1'b0, a, 32'h0);
        end
    endtask
    task rd_all;
        begin
            rd(8'h00, {mode, legacy});
            rd(8'h04, sw0);
            rd(8'h08, sw1);
            rd(8'h0c, prod);
            rd(8'h10, acc);
            rd(8'h14, mc);
            rd(8'h18, t1);
            rd(8'h1c, t2);
            rd(8'h20, {lastn, 1'b0});
            rd(8'h24, 33'h1_0000_0000);
        end
    endtask
    function [31:0] shf(input [31:0] v);
        case (mode)
            2'h0: shf = v;
            2'h1: shf = v << 1;
            2'h2: shf = v << 4;
            default: shf = $signed(v) >>> 6;
        endcase
    endfunction
    // Valid stays up after return so the next call can follow at once
    task issue(input logic [1:0] o, input logic s, input logic [7:0] a, input logic p, input logic [7:0] r);
        logic [15:0] d;
        begin
            d = tmem[a];
            iv    <= 1'b1;
            op    <= o;
            sel   <= s;
            maddr <= a;
            per   <= p;
            rpt   <= r;
            nxt   <= rv[31:28];
            lastn = (r + 11'h1) * ((o == 2'h0 ? 11'h2 : 11'h1) + p) + a[7];
            exp_cyc.push_back(lastn);
            case (o)
                2'h0: if (s) begin
                    sw1 = d;
                    sw0[15:13] = d[15:13];
                end else
                    sw0 = {d[15:10], sw0[9], d[8:0]};
                2'h1: prod = {d, prod[15:0]};
                default: begin
                    mc = d;
                    if (!legacy) begin
                        t1 = d[4:0];
                        t2 = d[3:0];
                    end
                    if (o[0])
                        acc = acc + shf(prod);
                end
            endcase
            @(posedge clk);
            while (ready !== 1'b1)
                @(posedge clk);
        end
    endtask
    task settle;
        begin
            iv <= 1'b0;
            while (exp_cyc.size() != 0)
                @(posedge clk);
            rd_all;
        end
    endtask
    initial begin
        rv = $urandom(23246);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 256; i++) begin
            tmem[i] = $urandom;
            mwr   <= 1'b1;
            maddr <= i[7:0];
            mwd   <= tmem[i];
            @(posedge clk);
        end
        mwr <= 1'b0;
        rd_all;
        for (j = 0; j < 8; j++) begin
            mode = j[2:1];
            legacy = j[0];
            apb(1'b1, 8'h00, {mode, legacy});
            prod = $urandom;
            apb(1'b1, 8'h0c, prod);
            for (i = 0; i < 6; i++) begin
                rv = $urandom;
                issue(rv[1:0], rv[2], rv[10:3], rv[11], {6'h0, rv[13:12]});
            end
            settle;
        end
        // Longest repeat count with both extras on a status one load
        issue(2'h0, 1'b1, 8'h80, 1'b1, 8'hff);
        settle;
        // Fixed cases so each timing assertion sees its trigger at least once
        issue(2'h0, 1'b0, 8'h81, 1'b0, 8'h00);
        issue(2'h2, 1'b0, 8'h01, 1'b1, 8'h00);
        issue(2'h3, 1'b1, 8'h02, 1'b0, 8'h00);
        settle;
        // Enable low freezes state, so this accumulator write must be lost
        ce <= 1'b0;
        apb(1'b1, 8'h10, 32'h0bad_cafe);
        ce <= 1'b1;
        apb(1'b1, 8'h14, 32'h0000_a5c3);
        mc = 16'ha5c3;
        apb(1'b1, 8'h18, 32'hffff_ffff);
        t1 = 5'h1f;
        apb(1'b1, 8'h20, 32'h0000_0ffe);
        apb(1'b1, 8'h24, 32'h1234_5678);
        rd_all;
        test_done;
    end
    initial begin
        #(25 * 30000);
        error_cnt++;
        test_done;
    end
endmodule
